/* core/rss_pkg.sv */
// Shared constants, carriers and types of the receive sync status reporter
package rss_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Character status codes
  localparam logic [2:0] RSS_ST_NORMAL = 3'h0;
  localparam logic [2:0] RSS_ST_SPECIAL = 3'h1;
  localparam logic [2:0] RSS_ST_LOCK = 3'h2;
  localparam logic [2:0] RSS_ST_FRAME = 3'h3;
  localparam logic [2:0] RSS_ST_VIOL = 3'h4;
  localparam logic [2:0] RSS_ST_LOSS = 3'h5;
  localparam logic [2:0] RSS_ST_DISP = 3'h6;
  localparam logic [2:0] RSS_ST_RESYNC = 3'h7;

  // Substitute special characters, byte layout {y[2:0], x[4:0]} for Cx.y
  localparam logic [7:0] RSS_C0_7 = 8'hE0;
  localparam logic [7:0] RSS_C4_7 = 8'hE4;

  ////////////////////////////////////////////////////////////////////////////
  // Counts
  localparam logic [2:0] RSS_FRAME_RUN = 3'h4;
  localparam logic [2:0] RSS_DEC_ERR_RUN = 3'h4;
  localparam logic [2:0] RSS_IMV_LIMIT = 3'h4;
  localparam int RSS_SYNC_STAGES = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Register map and reset values
  localparam int RSS_ADDR_W = 8;
  localparam logic [7:0] RSS_REG_INT_STATUS = 8'h00;
  localparam logic [7:0] RSS_REG_INT_MASK = 8'h04;
  localparam logic [7:0] RSS_REG_SYNC_STAT = 8'h08;
  localparam int RSS_IRQ_W = 5;
  localparam logic [4:0] RSS_INT_MASK_RST = 5'h00;
  localparam logic [4:0] RSS_INT_STATUS_RST = 5'h00;
  localparam int RSS_IRQ_LOST = 0;
  localparam int RSS_IRQ_GAIN = 1;
  localparam int RSS_IRQ_VIOL = 2;
  localparam int RSS_IRQ_DISP = 3;
  localparam int RSS_IRQ_FAULT = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    RSS_NO_SYNC = 2'b00,
    RSS_RESYNC = 2'b01,
    RSS_IN_SYNC = 2'b10
  } rss_sync_e;

  // One decoded character from the decoder
  typedef struct packed {
    logic valid;
    logic special;
    logic [7:0] data;
    logic viol;
    logic disp_err;
  } rss_char_s;

  // Decoded character with its classification
  typedef struct packed {
    logic valid;
    logic special;
    logic [7:0] data;
    logic framing;
    logic viol;
    logic disp;
    logic good;
  } rss_class_s;

  // Read-only sync status word
  typedef struct packed {
    logic [13:0] zero_hi;
    logic pll_locked;
    logic type_b;
    logic zero_imv;
    logic [2:0] imv_cnt;
    logic zero_de;
    logic [2:0] de_cnt;
    logic zero_fr;
    logic [2:0] fr_cnt;
    logic [1:0] zero_st;
    logic [1:0] sync;
  } rss_sync_stat_s;

endpackage

/* core/rss_pin_sync.sv */
// Three-stage synchroniser for pin inputs with agreement filter
module rss_pin_sync
  import rss_pkg::*;
#(
  parameter int W = 1
) (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } rss_psync_s;

  rss_psync_s r;
  rss_psync_s r_nxt;

  always_comb begin
    r_nxt = r;
    r_nxt.s1 = pin_in;
    r_nxt.s2 = r.s1;
    r_nxt.s3 = r.s2;
    // A change counts only once the later two stages agree
    for (int i = 0; i < W; i++) begin
      if (r.s2[i] == r.s3[i]) begin
        r_nxt.q[i] = r.s3[i];
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      r <= '0;
    end else if (ce_in) begin
      r <= r_nxt;
    end
  end

  assign level_out = r.q;

endmodule

/* core/rss_char_class.sv */
// Classifies one decoded character against the selected framing character
module rss_char_class
  import rss_pkg::*;
(
  input wire rss_char_s char_in,
  input wire logic [8:0] framing_in,
  output rss_class_s class_out
);

  logic dec_err;

  assign dec_err = char_in.viol | char_in.disp_err;

  // One process fills the whole carrier so it has a single driver
  always_comb begin
    class_out.valid = char_in.valid;
    class_out.special = char_in.special;
    class_out.data = char_in.data;
    class_out.viol = char_in.viol;
    class_out.disp = char_in.disp_err & ~char_in.viol;
    class_out.good = char_in.valid & ~dec_err;
    // A damaged character never counts as framing
    class_out.framing = char_in.valid & ~dec_err &
                        ({char_in.special, char_in.data} == framing_in);
  end

endmodule

/* core/rss_reporter.sv */
// Receive character status encoder and sync state machine with registers
//
// The implementer's own choices: the plain strobed port and the register offsets.
module rss_reporter
  import rss_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  input wire rss_char_s rx_char_in,
  input wire logic pll_lock_in,
  input wire logic status_report_type_select_in,
  input wire logic [8:0] selected_framing_character_in,
  input wire logic bonding_en_in,
  input wire logic bonded_in,
  input wire logic deskew_expired_in,
  input wire logic ebuf_fault_in,
  input wire logic [RSS_ADDR_W-1:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [2:0] rx_char_status_code_out,
  output logic [7:0] rx_data_out,
  output logic rx_special_out,
  output logic rx_valid_out,
  output logic irq_out,
  output logic [31:0] reg_rdata_out
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    rss_class_s stg;
    rss_sync_e sync;
    logic [2:0] fr_cnt;
    logic [2:0] de_cnt;
    logic [2:0] imv_cnt;
    logic [RSS_IRQ_W-1:0] irq_st;
    logic [RSS_IRQ_W-1:0] irq_mask;
    logic [2:0] code;
    logic [7:0] data;
    logic special;
    logic valid;
    logic irq;
    logic [31:0] rdata;
  } rss_state_s;

  rss_state_s r;
  rss_state_s r_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Pin inputs and classification

  logic [10:0] pins_sync;
  logic pll_locked;
  logic type_b;
  logic [8:0] framing;
  rss_class_s cls;

  rss_pin_sync #(
    .W(11)
  ) u_pin_sync (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .pin_in({pll_lock_in, status_report_type_select_in, selected_framing_character_in}),
    .level_out(pins_sync)
  );

  assign pll_locked = pins_sync[10];
  assign type_b = pins_sync[9];
  assign framing = pins_sync[8:0];

  rss_char_class u_char_class (
    .char_in(rx_char_in),
    .framing_in(framing),
    .class_out(cls)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Conditions on the staged character; the new input is its lookahead

  logic fault;
  logic dec_err;
  logic no_bond_expiry;
  logic lock_hit;
  logic loss;
  logic [RSS_IRQ_W-1:0] irq_ev;
  logic [RSS_IRQ_W-1:0] irq_clr;
  rss_sync_stat_s stat_word;

  assign fault = ~pll_locked | ebuf_fault_in;
  assign dec_err = r.stg.valid & (r.stg.viol | r.stg.disp);
  assign no_bond_expiry = deskew_expired_in & ~bonded_in;
  // Last framing character before a good one, channels bonded
  assign lock_hit = type_b & (r.sync == RSS_RESYNC) & r.stg.framing & cls.good &
                    ~cls.framing & bonded_in;
  // Lost framing or alignment only means something once bonding is enabled
  assign loss = fault | (bonding_en_in & (r.sync == RSS_NO_SYNC));

  always_comb begin
    stat_word = '0;
    stat_word.sync = r.sync;
    stat_word.fr_cnt = r.fr_cnt;
    stat_word.de_cnt = r.de_cnt;
    stat_word.imv_cnt = r.imv_cnt;
    stat_word.type_b = type_b;
    stat_word.pll_locked = pll_locked;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    r_nxt = r;
    r_nxt.stg = cls;
    irq_ev = '0;
    irq_clr = '0;

    // Run counters advance once per staged character
    if (r.stg.valid) begin
      if (r.stg.framing) begin
        if (r.fr_cnt != RSS_FRAME_RUN) begin
          r_nxt.fr_cnt = r.fr_cnt + 3'h1;
        end
      end else begin
        r_nxt.fr_cnt = 3'h0;
      end
      if (dec_err) begin
        if (r.de_cnt != RSS_DEC_ERR_RUN) begin
          r_nxt.de_cnt = r.de_cnt + 3'h1;
        end
        if (r.imv_cnt != RSS_IMV_LIMIT) begin
          r_nxt.imv_cnt = r.imv_cnt + 3'h1;
        end
      end else begin
        r_nxt.de_cnt = 3'h0;
        if (r.imv_cnt != 3'h0) begin
          r_nxt.imv_cnt = r.imv_cnt - 3'h1;
        end
      end
    end

    case (r.sync)
      RSS_NO_SYNC: begin
        if (type_b && (no_bond_expiry || dec_err)) begin
          r_nxt.fr_cnt = 3'h0;
        end else if (r.stg.framing && r.fr_cnt == RSS_FRAME_RUN - 3'h1) begin
          r_nxt.sync = RSS_RESYNC;
        end
      end
      RSS_RESYNC: begin
        if (dec_err || (type_b && no_bond_expiry)) begin
          r_nxt.sync = RSS_NO_SYNC;
        end else if (!type_b && r.stg.good && !r.stg.framing) begin
          r_nxt.sync = RSS_IN_SYNC;
        end else if (lock_hit) begin
          r_nxt.sync = RSS_IN_SYNC;
        end
      end
      RSS_IN_SYNC: begin
        if (dec_err && (r.de_cnt == RSS_DEC_ERR_RUN - 3'h1 ||
                        r.imv_cnt == RSS_IMV_LIMIT - 3'h1)) begin
          r_nxt.sync = RSS_NO_SYNC;
        end
      end
      default: begin
        r_nxt.sync = RSS_NO_SYNC;
      end
    endcase

    // Faults override every state
    if (fault) begin
      r_nxt.sync = RSS_NO_SYNC;
    end
    // Every fresh hunt starts from empty counters
    if (r_nxt.sync == RSS_NO_SYNC && r.sync != RSS_NO_SYNC) begin
      r_nxt.fr_cnt = 3'h0;
      r_nxt.de_cnt = 3'h0;
      r_nxt.imv_cnt = 3'h0;
    end

    // Status code, most urgent first
    r_nxt.valid = r.stg.valid;
    r_nxt.special = r.stg.special;
    r_nxt.data = r.stg.data;
    if (loss) begin
      r_nxt.code = RSS_ST_LOSS;
    end else if (bonding_en_in && lock_hit) begin
      r_nxt.code = RSS_ST_LOCK;
    end else if (r.sync == RSS_RESYNC) begin
      r_nxt.code = RSS_ST_RESYNC;
      r_nxt.data = framing[7:0];
      r_nxt.special = framing[8];
    end else if (r.stg.viol) begin
      r_nxt.code = RSS_ST_VIOL;
      r_nxt.data = RSS_C0_7;
      r_nxt.special = 1'b1;
    end else if (r.stg.framing) begin
      r_nxt.code = RSS_ST_FRAME;
    end else if (r.stg.disp) begin
      r_nxt.code = RSS_ST_DISP;
      r_nxt.data = RSS_C4_7;
      r_nxt.special = 1'b1;
    end else if (r.stg.special) begin
      r_nxt.code = RSS_ST_SPECIAL;
    end else begin
      r_nxt.code = RSS_ST_NORMAL;
    end

    // Interrupt events
    irq_ev[RSS_IRQ_LOST] = (r.sync != RSS_NO_SYNC) && (r_nxt.sync == RSS_NO_SYNC);
    irq_ev[RSS_IRQ_GAIN] = (r.sync != RSS_IN_SYNC) && (r_nxt.sync == RSS_IN_SYNC);
    irq_ev[RSS_IRQ_VIOL] = r.stg.valid & r.stg.viol;
    irq_ev[RSS_IRQ_DISP] = r.stg.valid & r.stg.disp;
    irq_ev[RSS_IRQ_FAULT] = fault;

    // Register writes; a new event beats a clear in the same cycle
    if (reg_wr_in) begin
      if (reg_addr_in == RSS_REG_INT_STATUS) begin
        irq_clr = reg_wdata_in[RSS_IRQ_W-1:0];
      end else if (reg_addr_in == RSS_REG_INT_MASK) begin
        r_nxt.irq_mask = reg_wdata_in[RSS_IRQ_W-1:0];
      end
    end
    r_nxt.irq_st = (r.irq_st & ~irq_clr) | irq_ev;
    r_nxt.irq = |(r_nxt.irq_st & r_nxt.irq_mask);

    // Read data stands for one cycle only; unmapped reads return zero
    r_nxt.rdata = 32'h0;
    if (reg_rd_in) begin
      if (reg_addr_in == RSS_REG_INT_STATUS) begin
        r_nxt.rdata = {27'h0, r.irq_st};
      end else if (reg_addr_in == RSS_REG_INT_MASK) begin
        r_nxt.rdata = {27'h0, r.irq_mask};
      end else if (reg_addr_in == RSS_REG_SYNC_STAT) begin
        r_nxt.rdata = stat_word;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      r <= '0;
    end else if (ce_in) begin
      r <= r_nxt;
    end
  end

  assign rx_char_status_code_out = r.code;
  assign rx_data_out = r.data;
  assign rx_special_out = r.special;
  assign rx_valid_out = r.valid;
  assign irq_out = r.irq;
  assign reg_rdata_out = r.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!nrst_in);

  frame_code_a: assert property (
    ce_in && !loss && !(bonding_en_in && lock_hit) && r.sync != RSS_RESYNC &&
    r.stg.framing |=> r.code == RSS_ST_FRAME && r.data == $past(r.stg.data))
    else $error("framing character not reported as 011");

  viol_sub_a: assert property (
    r.code == RSS_ST_VIOL |-> r.data == RSS_C0_7 && r.special)
    else $error("violation without C0.7 substitute");

  bond_loss_a: assert property (
    ce_in && bonding_en_in && r.sync == RSS_NO_SYNC |=> r.code == RSS_ST_LOSS)
    else $error("bonded no-sync not reported as 101");

  fault_code_a: assert property (
    ce_in && fault |=> r.code == RSS_ST_LOSS && r.sync == RSS_NO_SYNC)
    else $error("fault not reported as 101 with sync dropped");

  disp_sub_a: assert property (
    r.code == RSS_ST_DISP |-> r.data == RSS_C4_7 && r.special)
    else $error("disparity error without C4.7 substitute");

  resync_code_a: assert property (
    ce_in && r.sync == RSS_RESYNC && !loss && !(bonding_en_in && lock_hit)
    |=> r.code == RSS_ST_RESYNC && r.data == $past(framing[7:0]))
    else $error("resync state not reported as 111");

  a_err_drop_a: assert property (
    ce_in && !type_b && r.sync == RSS_RESYNC && dec_err |=> r.sync == RSS_NO_SYNC)
    else $error("type-A resync kept on decoder error");

  four_err_a: assert property (
    ce_in && r.sync == RSS_IN_SYNC && dec_err && r.de_cnt == 3'h3
    |=> r.sync == RSS_NO_SYNC)
    else $error("fourth decoder error did not drop sync");

  frame_run_a: assert property (
    ce_in && !fault && r.sync == RSS_NO_SYNC && r.stg.framing && r.fr_cnt == 3'h3 &&
    !(type_b && no_bond_expiry) |=> r.sync == RSS_RESYNC)
    else $error("four framing characters did not start resync");

  a_enter_a: assert property (
    ce_in && !fault && !type_b && r.sync == RSS_RESYNC && r.stg.good && !r.stg.framing
    |=> r.sync == RSS_IN_SYNC)
    else $error("type-A did not enter sync");

  lock_code_a: assert property (
    ce_in && !fault && bonding_en_in && lock_hit
    |=> r.code == RSS_ST_LOCK && r.sync == RSS_IN_SYNC)
    else $error("bonded lock not reported as 010");

  b_expiry_drop_a: assert property (
    ce_in && type_b && r.sync == RSS_RESYNC && no_bond_expiry |=> r.sync == RSS_NO_SYNC)
    else $error("type-B resync kept on unbonded deskew expiry");

  b_expiry_clear_a: assert property (
    ce_in && !fault && type_b && r.sync == RSS_NO_SYNC && no_bond_expiry
    |=> r.fr_cnt == 3'h0)
    else $error("type-B expiry did not clear the framing run");

  irq_set_a: assert property (
    ce_in && irq_ev[RSS_IRQ_LOST] |=> r.irq_st[RSS_IRQ_LOST])
    else $error("sync loss event not latched");

endmodule

/* test/rss_host_model.sv */
// Host-side model: picks the report type and counts delivered characters
module rss_host_model
  import rss_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic want_type_b_in,
  input wire logic rx_valid_in,
  output logic type_select_out,
  output logic [15:0] n_chars_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Static choice; only changed between streams so no character sees a mix
  assign type_select_out = want_type_b_in;

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      n_chars_out <= 16'h0000;
    end else if (rx_valid_in) begin
      n_chars_out <= n_chars_out + 16'h0001;
    end
  end
endmodule

/* test/rss_reporter_bench.sv */
// Self-checking bench for the receive sync status reporter
module rss_reporter_bench import rss_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0] FR = 8'hBC;
  localparam logic [7:0] DA = 8'h4A;
  localparam rss_char_s C_FR = {1'b1, 1'b1, FR, 1'b0, 1'b0};
  localparam rss_char_s C_DA = {1'b1, 1'b0, DA, 1'b0, 1'b0};
  localparam rss_char_s C_VI = {1'b1, 1'b0, 8'h00, 1'b1, 1'b0};
  localparam rss_char_s C_DS = {1'b1, 1'b0, DA, 1'b0, 1'b1};
  localparam rss_char_s C_VD = {1'b1, 1'b0, DA, 1'b1, 1'b1};

  logic sys_clk, nrst, ce, pll_lock, want_b, type_sel, bond_en, bonded, deskew, ebuf;
  logic [8:0] fchar;
  rss_char_s rx_char;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, rd_val;
  logic wr, rd, spec, vld, irq;
  logic [2:0] code;
  logic [7:0] dout;
  logic [15:0] n_chars;
  int n_fail, n_compared;
  logic [12:0] exp_q[$];

  rss_reporter uut (.sys_clk_in(sys_clk), .nrst_in(nrst), .ce_in(ce), .rx_char_in(rx_char),
    .pll_lock_in(pll_lock), .status_report_type_select_in(type_sel),
    .selected_framing_character_in(fchar), .bonding_en_in(bond_en), .bonded_in(bonded),
    .deskew_expired_in(deskew), .ebuf_fault_in(ebuf), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .rx_char_status_code_out(code),
    .rx_data_out(dout), .rx_special_out(spec), .rx_valid_out(vld), .irq_out(irq),
    .reg_rdata_out(rdata));

  rss_host_model host (.sys_clk_in(sys_clk), .nrst_in(nrst), .want_type_b_in(want_b),
    .rx_valid_in(vld), .type_select_out(type_sel), .n_chars_out(n_chars));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out;
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Output of a character lands two edges after it is driven, so the
  // expectation queue is popped two calls later
  task automatic tx(input rss_char_s c, input logic ckc, input logic [2:0] ec,
                    input logic ckd, input logic [7:0] ed);
    logic [12:0] e;
    @(posedge sys_clk);
    rx_char <= c;
    exp_q.push_back({ckc, ckd, ec, ed});
    #1;
    if (exp_q.size() > 2) begin
      e = exp_q.pop_front();
      if (e[12]) check("status code", code, e[10:8]);
      if (e[11]) check("out data", dout, e[7:0]);
      if (e[11]) check("out special", spec, e[7:0] != DA);
      if (e[12]) check("out valid", vld, 1'b1);
    end
  endtask

  // Leaves a good data character held, which moves no sync state except a type-A resync into sync
  task automatic drain;
    repeat (2) tx(C_DA, 1'b0, 3'h0, 1'b0, 8'h00);
    exp_q.delete();
  endtask

  task automatic run_fr(input int n, input logic [2:0] ec, input logic ckd);
    repeat (n) tx(C_FR, 1'b1, ec, ckd, FR);
  endtask

  task automatic enter_a;
    run_fr(4, RSS_ST_FRAME, 1'b1);
    tx(C_DA, 1'b1, RSS_ST_RESYNC, 1'b1, FR);
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1;
    rd_val = rdata;
  endtask

  task automatic sync_is(input logic [1:0] e);
    rd_reg(RSS_REG_SYNC_STAT);
    check("sync state", rd_val[1:0], e);
  endtask

  task automatic settle;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    repeat (20) @(posedge sys_clk);
    #1;
    check("code in reset", code, 3'h0);
    check("irq in reset", irq, 1'b0);
    check("valid in reset", vld, 1'b0);
    nrst <= 1'b1;
    repeat (8) @(posedge sys_clk);
    rd_reg(RSS_REG_INT_MASK);
    check("mask reset", rd_val, 32'h0000_0000);
    // The pin synchroniser reads unlocked for its first edges, so the fault bit is set
    rd_reg(RSS_REG_INT_STATUS);
    check("status reset", rd_val, 32'h0000_0010);
    check("chars before stream", n_chars, 16'h0000);
    wr_reg(8'h0C, 32'h0000_001F);
    rd_reg(8'h0C);
    check("unmapped", rd_val, 32'h0000_0000);
    wr_reg(RSS_REG_SYNC_STAT, 32'hFFFF_FFFF);
    rd_reg(RSS_REG_SYNC_STAT);
    check("sync stat", rd_val, 32'h0002_0000);
    $display("done reset");
  endtask

  task automatic t_type_a;
    run_fr(3, RSS_ST_FRAME, 1'b1);
    tx(C_DA, 1'b1, RSS_ST_NORMAL, 1'b1, DA);
    enter_a();
    tx(C_DA, 1'b1, RSS_ST_NORMAL, 1'b1, DA);
    drain();
    sync_is(2'h2);
    tx(C_VI, 1'b1, RSS_ST_VIOL, 1'b1, RSS_C0_7);
    tx(C_DS, 1'b1, RSS_ST_DISP, 1'b1, RSS_C4_7);
    tx(C_VD, 1'b1, RSS_ST_VIOL, 1'b1, RSS_C0_7);
    tx(C_VI, 1'b0, 3'h0, 1'b0, 8'h00);
    drain();
    sync_is(2'h0);
    enter_a();
    repeat (2) tx(C_VI, 1'b0, 3'h0, 1'b0, 8'h00);
    tx(C_DA, 1'b0, 3'h0, 1'b0, 8'h00);
    repeat (3) tx(C_VI, 1'b0, 3'h0, 1'b0, 8'h00);
    drain();
    sync_is(2'h0);
    run_fr(4, RSS_ST_FRAME, 1'b1);
    tx(C_VI, 1'b1, RSS_ST_RESYNC, 1'b1, FR);
    drain();
    sync_is(2'h0);
    $display("done type A");
  endtask

  task automatic t_faults;
    enter_a();
    drain();
    ebuf <= 1'b1;
    repeat (2) tx(C_DA, 1'b0, 3'h0, 1'b0, 8'h00);
    repeat (2) tx(C_DA, 1'b1, RSS_ST_LOSS, 1'b0, 8'h00);
    drain();
    ebuf <= 1'b0;
    sync_is(2'h0);
    enter_a();
    drain();
    pll_lock <= 1'b0;
    repeat (6) tx(C_DA, 1'b0, 3'h0, 1'b0, 8'h00);
    repeat (2) tx(C_DA, 1'b1, RSS_ST_LOSS, 1'b0, 8'h00);
    drain();
    sync_is(2'h0);
    pll_lock <= 1'b1;
    repeat (8) @(posedge sys_clk);
    $display("done faults");
  endtask

  task automatic t_type_b;
    want_b <= 1'b1;
    bond_en <= 1'b1;
    bonded <= 1'b1;
    repeat (6) @(posedge sys_clk);
    tx(C_DA, 1'b1, RSS_ST_LOSS, 1'b0, 8'h00);
    run_fr(4, RSS_ST_LOSS, 1'b0);
    tx(C_FR, 1'b1, RSS_ST_RESYNC, 1'b1, FR);
    tx(C_FR, 1'b1, RSS_ST_LOCK, 1'b0, 8'h00);
    tx(C_DA, 1'b1, RSS_ST_NORMAL, 1'b1, DA);
    drain();
    sync_is(2'h2);
    ebuf <= 1'b1;
    settle();
    ebuf <= 1'b0;
    bonded <= 1'b0;
    run_fr(4, RSS_ST_LOSS, 1'b0);
    tx(C_FR, 1'b1, RSS_ST_RESYNC, 1'b1, FR);
    tx(C_DA, 1'b1, RSS_ST_RESYNC, 1'b1, FR);
    drain();
    sync_is(2'h1);
    deskew <= 1'b1;
    settle();
    deskew <= 1'b0;
    sync_is(2'h0);
    run_fr(3, RSS_ST_LOSS, 1'b0);
    deskew <= 1'b1;
    tx(C_FR, 1'b1, RSS_ST_LOSS, 1'b0, 8'h00);
    deskew <= 1'b0;
    run_fr(1, RSS_ST_LOSS, 1'b0);
    drain();
    sync_is(2'h0);
    want_b <= 1'b0;
    bond_en <= 1'b0;
    bonded <= 1'b1;
    repeat (6) @(posedge sys_clk);
    $display("done type B");
  endtask

  task automatic t_irq;
    wr_reg(RSS_REG_INT_STATUS, 32'h0000_001F);
    tx(C_VI, 1'b0, 3'h0, 1'b0, 8'h00);
    drain();
    rd_reg(RSS_REG_INT_STATUS);
    check("int status", rd_val, 32'h0000_0004);
    wr_reg(RSS_REG_INT_MASK, 32'h0000_001B);
    settle();
    check("irq masked", irq, 1'b0);
    wr_reg(RSS_REG_INT_MASK, 32'h0000_001F);
    settle();
    check("irq raised", irq, 1'b1);
    rd_reg(RSS_REG_INT_MASK);
    check("int mask", rd_val, 32'h0000_001F);
    ce <= 1'b0;
    wr_reg(RSS_REG_INT_STATUS, 32'h0000_0004);
    settle();
    check("irq frozen", irq, 1'b1);
    ce <= 1'b1;
    wr_reg(RSS_REG_INT_STATUS, 32'h0000_0004);
    settle();
    check("irq cleared", irq, 1'b0);
    rd_reg(RSS_REG_INT_STATUS);
    check("status cleared", rd_val, 32'h0000_0000);
    $display("done interrupts");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // The whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    close_out();
  end

  initial begin
    n_fail = 0;
    n_compared = 0;
    nrst = 1'b0;
    ce = 1'b1;
    pll_lock = 1'b1;
    want_b = 1'b0;
    bond_en = 1'b0;
    bonded = 1'b1;
    deskew = 1'b0;
    ebuf = 1'b0;
    fchar = {1'b1, FR};
    rx_char = '0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    wr = 1'b0;
    rd = 1'b0;
    t_reset();
    t_type_a();
    t_faults();
    t_type_b();
    t_irq();
    close_out();
  end
endmodule
